// ==== irq_evt_ctrl.sv ====
// Interrupt controller with eight single-cycle event transfer channels
//
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module interrupt_and_event_transfer_ctrl (
  input wire logic clk_sys, // 200 MHz clock
  input wire logic rst_b, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic [7:0] src_evt, // Peripheral request pulses
  input wire logic [3:0] ext_pin, // Fast external inputs, async
  input wire logic [3:0] cpu_prio, // Current CPU priority level
  input wire logic irq_ack, // CPU takes presented interrupt
  input wire logic trap_req, // Trap instruction executed
  input wire logic [7:0] trap_num, // Trap number
  output logic irq_req, // Interrupt presented
  output logic [15:0] irq_vec, // Vector location
  output logic [3:0] irq_lvl, // Level of presented request
  output logic [2:0] irq_src, // Index of presented source
  output logic trap_go, // Trap vector pulse
  output logic [15:0] trap_vec, // Trap vector location
  output logic xfer, // One stolen cycle pulse
  output logic [15:0] xfer_src, // Transfer source address
  output logic [15:0] xfer_dst, // Transfer dest address
  output logic xfer_byte, // Byte rather than word
  output logic irq_out // Channel done interrupt
);

  // Behaviour in brief
  // One state struct holds every register; the next value is built in one
  // combinational pass and stored on every edge, so all outputs come from flops.
  //
  // Arbitration: among sources whose request and enable bits are both set, the
  // highest level wins and the lowest index breaks a tie. The winner competes
  // only when its level is above the level the CPU is running at, so a service
  // already in progress is preempted only by a strictly higher level.
  //
  // Response: a stable winner is offered after a fixed count of clocks. The
  // count restarts whenever the winner changes, which keeps a late arriving
  // higher level from being overtaken by an older, lower offer.
  //
  // Event transfer: a winner routed to a channel needs no CPU handshake. It is
  // served at once with a single stolen cycle and never while an offer stands,
  // so the CPU never sees a vector change under an offer it is about to take.
  // A finished non-continuous block hands its source back to the standard path
  // by clearing the route bit and raising the request again.
  //
  // Hazard: a channel count of zero in non-continuous mode wraps on the first
  // service, so software must load a non-zero count for a finite block.
  //
  // Flag priority within one clock: a hardware set wins over a software write
  // and over the clear that taking a service performs, so no event is lost.
  //
  // Register bus: the setup cycle prepares ready, error and read data, so every
  // transfer completes in its first access cycle with no wait state.

  typedef struct packed {
    logic [irq_evt_pkg::N_SRC-1:0][irq_evt_pkg::CTRL_W-1:0] ctrl;
    logic [irq_evt_pkg::N_CH-1:0][31:0] chptr;
    logic [irq_evt_pkg::N_CH-1:0][10:0] chcfg;
    logic [7:0] stat;
    logic [7:0] mask;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    logic [2:0] resp_cnt;
    logic [3:0] cand;
    logic irq_req;
    logic [15:0] irq_vec;
    logic [3:0] irq_lvl;
    logic [2:0] irq_src;
    logic trap_go;
    logic [15:0] trap_vec;
    logic xfer;
    logic [15:0] xfer_src;
    logic [15:0] xfer_dst;
    logic xfer_byte;
    logic irq_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  function automatic logic [3:0] prio_of(input logic [irq_evt_pkg::CTRL_W-1:0] c);
    prio_of = c[irq_evt_pkg::F_PRIO +: 4];
  endfunction : prio_of

  function automatic logic [15:0] vec_of(input logic [2:0] idx);
    vec_of = irq_evt_pkg::VEC_BASE + {11'h000, idx, 2'b00};
  endfunction : vec_of

  // Address window decode, shared by the read and write paths
  function automatic logic is_ctrl(input logic [7:0] a);
    is_ctrl = a < irq_evt_pkg::A_CHPTR;
  endfunction : is_ctrl

  // Channel pointer and config words share one window, split by bit 2
  function automatic logic is_chan(input logic [7:0] a);
    is_chan = a >= irq_evt_pkg::A_CHPTR && a < irq_evt_pkg::A_STAT;
  endfunction : is_chan

  logic found;
  logic [2:0] best;
  logic [3:0] best_lvl;
  logic wr;
  logic [2:0] ch;
  logic [7:0] cnt_new;
  logic [15:0] ptr_src;
  logic [15:0] ptr_dst;
  logic [15:0] step;
  logic rise;
  logic fall;
  logic [1:0] mode;

  always_comb begin
    s_nxt = s_r;
    found = 1'b0;
    best = 3'h0;
    best_lvl = 4'h0;
    ch = 3'h0;
    cnt_new = 8'h00;
    ptr_src = 16'h0000;
    ptr_dst = 16'h0000;
    step = 16'h0000;
    rise = 1'b0;
    fall = 1'b0;
    mode = 2'h0;
    s_nxt.xfer = 1'b0;
    s_nxt.trap_go = 1'b0;

    // Highest enabled pending source, lowest index on a tie
    // A strict compare keeps the first, lowest index source on equal levels
    for (int i = 0; i < irq_evt_pkg::N_SRC; i++) begin
      if (s_r.ctrl[i][irq_evt_pkg::F_REQ] && s_r.ctrl[i][irq_evt_pkg::F_EN]) begin
        if (!found || prio_of(s_r.ctrl[i]) > best_lvl) begin
          found = 1'b1;
          best = 3'(i);
          best_lvl = prio_of(s_r.ctrl[i]);
        end
      end
    end
    // Only a level above the running service may compete
    if (best_lvl <= cpu_prio) begin
      found = 1'b0;
    end

    // APB: pready and read data are prepared in the setup cycle
    s_nxt.pready = psel && !penable;
    s_nxt.pslverr = 1'b0;
    if (psel && !penable) begin
      // Unmapped or misaligned reads return zero along with the error flag
      s_nxt.prdata = 32'h0000_0000;

      if (is_ctrl(paddr)) begin
        if (paddr[1:0] == 2'b00 && paddr[7:2] < 6'(irq_evt_pkg::N_SRC)) begin
          s_nxt.prdata = {20'h00000, s_r.ctrl[paddr[4:2]]};
        end else begin
          s_nxt.pslverr = 1'b1;
        end
      end else if (is_chan(paddr)) begin
        if (paddr[1:0] != 2'b00) begin
          s_nxt.pslverr = 1'b1;
        end else if (paddr[2]) begin
          s_nxt.prdata = {21'h000000, s_r.chcfg[paddr[5:3]]};
        end else begin
          s_nxt.prdata = s_r.chptr[paddr[5:3]];
        end
      end else if (paddr == irq_evt_pkg::A_STAT) begin
        s_nxt.prdata = {24'h000000, s_r.stat};
      end else if (paddr == irq_evt_pkg::A_MASK) begin
        s_nxt.prdata = {24'h000000, s_r.mask};
      end else if (paddr == irq_evt_pkg::A_STATE) begin
        s_nxt.prdata = {24'h000000, s_r.irq_req, s_r.irq_src, s_r.irq_lvl};
      end else begin
        s_nxt.pslverr = 1'b1;
      end
    end

    // Writes land at the access edge that sees pready high
    // A refused transfer leaves every register untouched
    wr = psel && penable && pwrite && s_r.pready && !s_r.pslverr;

    if (wr) begin
      if (is_ctrl(paddr)) begin
        // A software set of the request flag is served like a hardware one
        s_nxt.ctrl[paddr[4:2]] = pwdata[irq_evt_pkg::CTRL_W-1:0];
      end else if (is_chan(paddr)) begin
        if (paddr[2]) begin
          s_nxt.chcfg[paddr[5:3]] = pwdata[10:0];
        end else begin
          s_nxt.chptr[paddr[5:3]] = pwdata;
        end
      end else if (paddr == irq_evt_pkg::A_STAT) begin
        // Write one to clear; a done event in the same clock sets it again below
        s_nxt.stat = s_r.stat & ~pwdata[7:0];
      end else if (paddr == irq_evt_pkg::A_MASK) begin
        s_nxt.mask = pwdata[7:0];
      end
    end

    // Standard interrupt handshake
    // The take clears the flag of the source that was offered, not the winner now

    if (s_r.irq_req && irq_ack) begin
      s_nxt.ctrl[s_r.irq_src][irq_evt_pkg::F_REQ] = 1'b0;
      s_nxt.irq_req = 1'b0;
    end else if (s_r.irq_req && (!found || best != s_r.irq_src)) begin
      // A better request or a raised CPU level withdraws the offer
      s_nxt.irq_req = 1'b0;
    end


    // Response counter restarts whenever the winner changes
    if (!found || {1'b1, best} != s_r.cand) begin
      s_nxt.resp_cnt = 3'h0;
      s_nxt.cand = found ? {1'b1, best} : 4'h0;
    end else if (s_r.resp_cnt != irq_evt_pkg::RESP_CNT) begin
      s_nxt.resp_cnt = s_r.resp_cnt + 3'h1;
    end


    if (found && s_r.ctrl[best][irq_evt_pkg::F_ROUTE] && !s_r.irq_req) begin
      // Channel service: no vector, one stolen cycle
      ch = s_r.ctrl[best][irq_evt_pkg::F_CH +: 3];
      ptr_src = s_r.chptr[ch][15:0];
      ptr_dst = s_r.chptr[ch][31:16];
      s_nxt.xfer = 1'b1;
      s_nxt.xfer_src = ptr_src;
      s_nxt.xfer_dst = ptr_dst;
      s_nxt.xfer_byte = s_r.chcfg[ch][irq_evt_pkg::F_BYTE];
      step = s_r.chcfg[ch][irq_evt_pkg::F_BYTE] ? 16'h0001 : 16'h0002;
      if (s_r.chcfg[ch][irq_evt_pkg::F_INC_DST]) begin
        s_nxt.chptr[ch][31:16] = ptr_dst + step;
      end else begin
        s_nxt.chptr[ch][15:0] = ptr_src + step;
      end
      s_nxt.ctrl[best][irq_evt_pkg::F_REQ] = 1'b0;
      cnt_new = s_r.chcfg[ch][irq_evt_pkg::F_CNT +: 8];
      if (!s_r.chcfg[ch][irq_evt_pkg::F_CONT]) begin
        cnt_new = cnt_new - 8'h01;
        s_nxt.chcfg[ch][irq_evt_pkg::F_CNT +: 8] = cnt_new;
      end
      if (!s_r.chcfg[ch][irq_evt_pkg::F_CONT] && cnt_new == 8'h00) begin
        // Block done: fall back to the source's own vector
        s_nxt.ctrl[best][irq_evt_pkg::F_ROUTE] = 1'b0;
        s_nxt.ctrl[best][irq_evt_pkg::F_REQ] = 1'b1;
        s_nxt.stat[ch] = 1'b1;
      end
    end else if (found && !s_r.irq_req && s_r.cand == {1'b1, best}
                 && s_r.resp_cnt == irq_evt_pkg::RESP_CNT) begin
      s_nxt.irq_req = 1'b1;
      s_nxt.irq_src = best;
      s_nxt.irq_lvl = best_lvl;
      s_nxt.irq_vec = vec_of(best);
    end


    // Hardware request sources; set wins over any clear above
    // Edge detection reads only the second synchroniser stage and its delayed copy
    s_nxt.sync1 = ext_pin;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev = s_r.sync2;
    for (int i = 0; i < irq_evt_pkg::N_SRC; i++) begin
      if (src_evt[i]) begin
        s_nxt.ctrl[i][irq_evt_pkg::F_REQ] = 1'b1;
      end
    end
    for (int i = 0; i < irq_evt_pkg::N_EXT; i++) begin
      rise = s_r.sync2[i] && !s_r.prev[i];
      fall = !s_r.sync2[i] && s_r.prev[i];
      mode = s_r.ctrl[i][irq_evt_pkg::F_EDGE +: 2];
      if ((rise && (mode == irq_evt_pkg::EDGE_RISE || mode == irq_evt_pkg::EDGE_BOTH))
          || (fall && (mode == irq_evt_pkg::EDGE_FALL
                       || mode == irq_evt_pkg::EDGE_BOTH))) begin
        s_nxt.ctrl[i][irq_evt_pkg::F_REQ] = 1'b1;
      end
    end


    // Trap instruction vectors by its own number, outside arbitration
    if (trap_req) begin
      s_nxt.trap_go = 1'b1;
      s_nxt.trap_vec = {6'h00, trap_num, 2'b00};
    end


    // Level output follows status and mask as they will stand after this edge
    s_nxt.irq_out = |(s_nxt.stat & s_nxt.mask);
  end

  // Register file and all output flops; ctrl, chptr and chcfg reset to package values, all other fields reset to zero

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      for (int i = 0; i < irq_evt_pkg::N_SRC; i++) begin
        s_r.ctrl[i] <= irq_evt_pkg::CTRL_RST;
      end
      for (int i = 0; i < irq_evt_pkg::N_CH; i++) begin
        s_r.chptr[i] <= irq_evt_pkg::CHPTR_RST;
        s_r.chcfg[i] <= irq_evt_pkg::CHCFG_RST;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  // Register bus answer
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;

  // Standard interrupt offer
  assign irq_req = s_r.irq_req;
  assign irq_vec = s_r.irq_vec;
  assign irq_lvl = s_r.irq_lvl;
  assign irq_src = s_r.irq_src;

  // Software trap
  assign trap_go = s_r.trap_go;
  assign trap_vec = s_r.trap_vec;

  // Stolen transfer cycle
  assign xfer = s_r.xfer;
  assign xfer_src = s_r.xfer_src;
  assign xfer_dst = s_r.xfer_dst;
  assign xfer_byte = s_r.xfer_byte;

  // Channel done level
  assign irq_out = s_r.irq_out;

endmodule : interrupt_and_event_transfer_ctrl

// ==== irq_evt_pkg.sv ====
// Constants, register map and field layout of the interrupt and event transfer controller
// Functional notes
// - Interrupt answered within 5 to 12 clocks
// - Each source routed to interrupt or channel
// - Channel service steals one cycle, no vector
// - Move byte or word, bump one pointer
// - Count down per service, except continuous
// - Count zero raises source's standard interrupt
// - Eight channels, own pointers and counter
// - Per source request, enable, priority register
// - Sixteen priority levels per source
// - Only strictly higher priority preempts service
// - Each source has own vector location
// - Fast inputs detect rise, fall or both
// - Trap instruction number selects the vector
// - Software set request flag acts as hardware
package irq_evt_pkg;
  localparam int N_SRC = 8;
  localparam int N_CH = 8;
  localparam int N_EXT = 4;
  // Source control word layout
  localparam int F_REQ = 0;
  localparam int F_EN = 1;
  localparam int F_PRIO = 2;
  localparam int F_ROUTE = 6;
  localparam int F_CH = 7;
  localparam int F_EDGE = 10;
  localparam int CTRL_W = 12;
  // Channel config layout
  localparam int F_CNT = 0;
  localparam int F_BYTE = 8;
  localparam int F_INC_DST = 9;
  localparam int F_CONT = 10;
  // Edge modes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Register map, byte addresses
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CHPTR = 8'h40;
  localparam logic [7:0] A_CHCFG = 8'h44;
  localparam logic [7:0] A_STAT = 8'h80;
  localparam logic [7:0] A_MASK = 8'h84;
  localparam logic [7:0] A_STATE = 8'h88;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [31:0] CHPTR_RST = 32'h0000_0000;
  localparam logic [10:0] CHCFG_RST = 11'h000;
  // Vector table base; source i sits at base plus 4*i
  localparam logic [15:0] VEC_BASE = 16'h0060;
  // Response timing in CPU clocks
  localparam int RESP_MIN_CLK = 5;
  localparam int RESP_MAX_CLK = 12;
  localparam logic [2:0] RESP_CNT = 3'(RESP_MIN_CLK - 2);
endpackage : irq_evt_pkg

// ==== irq_evt_monitor.sv ====
// Port checker for the interrupt and event transfer controller
`timescale 1ns/1ps
module irq_evt_monitor (
  input wire logic clk_sys, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic trap_req, // Trap request
  input wire logic [7:0] trap_num, // Trap number
  input wire logic trap_go, // Trap pulse
  input wire logic [15:0] trap_vec, // Trap vector
  input wire logic irq_req, // Offer
  input wire logic irq_ack, // CPU take
  input wire logic [15:0] irq_vec, // Vector
  input wire logic [3:0] irq_lvl, // Level
  input wire logic [2:0] irq_src, // Source
  input wire logic xfer, // Stolen cycle
  input wire logic irq_out // Done interrupt
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  AST_VEC: assert property (irq_req |-> irq_vec == irq_evt_pkg::VEC_BASE + {11'h0, irq_src, 2'h0})
    else $error("vector does not match source");
  AST_LVL: assert property (irq_req |-> irq_lvl != 4'h0)
    else $error("level zero offered");
  AST_ACK: assert property (irq_req && irq_ack |=> !irq_req)
    else $error("offer stays after take");
  AST_TRAP: assert property (trap_req |=> trap_go && trap_vec == {6'h0, $past(trap_num), 2'h0})
    else $error("trap vector wrong");
  AST_TRAP_ONE: assert property (trap_go |-> $past(trap_req))
    else $error("trap pulse without request");
  AST_READY: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  cover property (irq_req && irq_ack);
  cover property (xfer);
  cover property (irq_out);
endmodule : irq_evt_monitor
bind interrupt_and_event_transfer_ctrl irq_evt_monitor mon (.clk_sys, .rst_b, .psel, .penable,
  .pready, .pslverr, .trap_req, .trap_num, .trap_go, .trap_vec, .irq_req, .irq_ack, .irq_vec,
  .irq_lvl, .irq_src, .xfer, .irq_out);

// ==== cpu_model.sv ====
// CPU core model that takes offered interrupts promptly or slowly
`timescale 1ns/1ps
module cpu_model (
  input wire logic clk_sys, // Clock
  input wire logic rst_b, // Reset, low
  input wire logic irq_req, // Offer
  input wire logic slow, // Delay the take
  output logic irq_ack // Take
);
  logic [2:0] wait_r;
  // Slow mode lets other requests pile up behind the offer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wait_r <= 3'h0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= 1'b0;
      wait_r <= 3'h0;
      if (irq_req && !irq_ack && wait_r >= (slow ? 3'h6 : 3'h0)) begin
        irq_ack <= 1'b1;
      end else if (irq_req && !irq_ack) begin
        wait_r <= wait_r + 3'h1;
      end
    end
  end
endmodule : cpu_model

// ==== interrupt_and_event_transfer_ctrl_bench.sv ====
// Self-checking bench for the interrupt and event transfer controller
`timescale 1ns/1ps
module interrupt_and_event_transfer_ctrl_bench;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, irq_ack, trap_req, slow, e;
  logic irq_req, trap_go, xfer, xfer_byte, irq_out;
  logic [7:0] paddr, src_evt, trap_num, r;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] ext_pin, cpu_prio, irq_lvl;
  logic [2:0] irq_src;
  logic [15:0] irq_vec, trap_vec, xfer_src, xfer_dst;
  logic [16:0] exq[$];
  int fail_count = 0;
  int compares = 0;
  int s, p, n;
  interrupt_and_event_transfer_ctrl dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .src_evt, .ext_pin, .cpu_prio, .irq_ack, .trap_req,
    .trap_num, .irq_req, .irq_vec, .irq_lvl, .irq_src, .trap_go, .trap_vec, .xfer, .xfer_src,
    .xfer_dst, .xfer_byte, .irq_out);
  cpu_model cpu (.clk_sys, .rst_b, .irq_req, .slow, .irq_ack);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic pulse(input logic [7:0] m);
    src_evt <= m;
    @(posedge clk_sys);
    src_evt <= 8'h00;
  endtask : pulse
  task automatic drain(input string t);
    for (int i = 0; i < 400 && exq.size() != 0; i++) @(posedge clk_sys);
    chk(exq.size(), 0);
    $display("test %s done", t);
  endtask : drain
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  // Results come in order, so the oldest note always matches
  always @(posedge clk_sys) begin
    if (xfer === 1'b1 || (irq_req === 1'b1 && irq_ack === 1'b1)) begin
      if (exq.size() == 0) chk(32'h1, 32'h0);
      else chk({xfer, xfer ? xfer_src : irq_vec}, exq.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    summarize();
  end
  initial begin
    {rst_b, psel, penable, pwrite, trap_req, slow} = 6'h00;
    {paddr, src_evt, trap_num, pwdata, ext_pin, cpu_prio} = '0;
    r = 8'h18;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, irq_evt_pkg::CTRL_RST);
    apb(1'b0, 8'hfc, 32'h0);
    chk(e, 32'h1);
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      s = r % 8;
      r = lfsr(r);
      p = 1 + r % 15;
      slow <= r[6];
      apb(1'b1, 8'(4 * s), {26'h0, p[3:0], 2'h2});
      exq.push_back({1'b0, irq_evt_pkg::VEC_BASE + 16'(4 * s)});
      pulse(8'h01 << s);
      n = 1;
      while (irq_req !== 1'b1 && n < 20) begin
        @(posedge clk_sys);
        n++;
      end
      chk(n >= 5 && n <= 12, 32'h1);
      drain("random");
    end
    slow <= 1'b1;
    apb(1'b1, 8'h04, 32'h0a);
    apb(1'b1, 8'h08, 32'h26);
    exq.push_back(17'h00068);
    exq.push_back(17'h00064);
    pulse(8'h06);
    drain("priority");
    slow <= 1'b0;
    cpu_prio <= r[3:0] | 4'hf;
    apb(1'b1, 8'h0c, 32'h3f);
    repeat (20) @(posedge clk_sys);
    chk(irq_req, 32'h0);
    exq.push_back(17'h0006c);
    cpu_prio <= 4'h0;
    drain("software");
    r = lfsr(r);
    trap_num <= r;
    trap_req <= 1'b1;
    @(posedge clk_sys);
    trap_req <= 1'b0;
    @(posedge clk_sys);
    chk({trap_go, trap_vec}, {1'b1, 6'h0, r, 2'h0});
    apb(1'b1, 8'h10, 32'h4e);
    apb(1'b1, 8'h40, 32'h2000_1000);
    apb(1'b1, 8'h44, 32'h2);
    apb(1'b1, 8'h84, 32'h1);
    exq.push_back(17'h11000);
    exq.push_back(17'h11002);
    exq.push_back(17'h00070);
    pulse(8'h10);
    repeat (10) @(posedge clk_sys);
    pulse(8'h10);
    drain("channel");
    chk(irq_out, 32'h1);
    apb(1'b1, 8'h84, 32'h0);
    chk(irq_out, 32'h0);
    apb(1'b1, 8'h84, 32'h1);
    apb(1'b1, 8'h80, 32'h1);
    chk(irq_out, 32'h0);
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, 8'h00, 32'(m << 10) | 32'h12);
      if (m != 2) exq.push_back(17'h00060);
      if (m != 1) exq.push_back(17'h00060);
      r = lfsr(r);
      ext_pin <= {r[3:1], 1'b1};
      repeat (30) @(posedge clk_sys);
      ext_pin <= 4'h0;
      repeat (30) @(posedge clk_sys);
      drain("edge");
    end
    summarize();
  end
endmodule : interrupt_and_event_transfer_ctrl_bench
